/* File: core/hdlc_txcount_test_loopback.sv */
// HDLC transmit length counter, test control, loopbacks and test status
//
// Contract
// - Count of one tags next write end
// - Counter decrements when FIFO write completes
// - Repeat bit reloads count on each expiry
// - High byte applies on next low write
// - Soft reset resets block, keeps itself
// - Soft reset clears on two zero writes
// - Receive loopback copies bytes into both FIFOs unless a swapped processor write takes the receive FIFO
// - Looped bytes sent like processor writes
// - CRC probe shifts 16 clocks then stops
// - CRC match on F0B8, bits corruptible
// - FIFO swap redirects writes and reads
// - Swap passes tag bits both ways
// - Address probe shifts 16 clocks then stops
// - Transmit loopback feeds tx into receiver
// - Status 3 shows gated receive clock
// - Status 2 shows gated transmit clock
// - Status 1 shows CRC comparison match
// - Status 0 shows address comparison match
`timescale 1ns/1ps
`default_nettype none
module hdlc_txcount_test_loopback (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_b,
   // Register port
   input  wire hdlc_test_pkg::reg_req_t  reg_req,
   output logic [7:0]                    reg_rdata,
   // Processor FIFO access
   input  wire logic                     cpu_tx_wr,
   input  wire hdlc_test_pkg::fifo_word_t cpu_tx_word,
   input  wire logic                     cpu_rx_rd,
   input  wire hdlc_test_pkg::fifo_word_t tx_fifo_out,
   input  wire hdlc_test_pkg::fifo_word_t rx_fifo_out,
   output hdlc_test_pkg::fifo_word_t     cpu_rd_word,
   // Receiver byte stream
   input  wire logic                     rx_byte_valid,
   input  wire hdlc_test_pkg::fifo_word_t rx_byte,
   // FIFO write and read ports
   output logic                          tx_fifo_wr,
   output hdlc_test_pkg::fifo_word_t     tx_fifo_word,
   output logic                          rx_fifo_wr,
   output hdlc_test_pkg::fifo_word_t     rx_fifo_word,
   output logic                          tx_fifo_rd,
   output logic                          rx_fifo_rd,
   // Controls from other registers
   input  wire logic                     repeat_count_ctl,
   input  wire logic                     receiver_enable_ctl,
   input  wire logic                     transmitter_enable_ctl,
   // Serial path
   input  wire logic                     rx_serial_clock,
   input  wire logic                     rx_serial_data,
   input  wire logic                     tx_bit_clock,
   input  wire logic                     tx_serial_data,
   input  wire logic [15:0]              addr_match_value,
   input  wire logic [15:0]              crc_corrupt_mask,
   output logic                          rx_data_to_receiver,
   output logic                          rx_clock_run,
   output logic                          block_reset_b
);
   import hdlc_test_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers (3 stages, change counts when 2 and 3 agree)
   // ------------------------------------------------------------
   logic [2:0] rxc_sync_ff, rxd_sync_ff, txc_sync_ff, txd_sync_ff;
   logic [2:0] nxt_rxc_sync, nxt_rxd_sync, nxt_txc_sync, nxt_txd_sync;
   logic       rxc_ff, rxd_ff, txc_ff, txd_ff;
   logic       nxt_rxc, nxt_rxd, nxt_txc, nxt_txd;
   logic       rxc_prev_ff, nxt_rxc_prev;
   always_comb begin
      nxt_rxc_sync = {rxc_sync_ff[1:0], rx_serial_clock};
      nxt_rxd_sync = {rxd_sync_ff[1:0], rx_serial_data};
      nxt_txc_sync = {txc_sync_ff[1:0], tx_bit_clock};
      nxt_txd_sync = {txd_sync_ff[1:0], tx_serial_data};
      nxt_rxc = (rxc_sync_ff[1] == rxc_sync_ff[2]) ? rxc_sync_ff[2] : rxc_ff;
      nxt_rxd = (rxd_sync_ff[1] == rxd_sync_ff[2]) ? rxd_sync_ff[2] : rxd_ff;
      nxt_txc = (txc_sync_ff[1] == txc_sync_ff[2]) ? txc_sync_ff[2] : txc_ff;
      nxt_txd = (txd_sync_ff[1] == txd_sync_ff[2]) ? txd_sync_ff[2] : txd_ff;
      nxt_rxc_prev = rxc_ff;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rxc_sync_ff <= 3'h0;
         rxd_sync_ff <= 3'h0;
         txc_sync_ff <= 3'h0;
         txd_sync_ff <= 3'h0;
         rxc_ff      <= 1'b0;
         rxd_ff      <= 1'b0;
         txc_ff      <= 1'b0;
         txd_ff      <= 1'b0;
         rxc_prev_ff <= 1'b0;
      end else begin
         rxc_sync_ff <= nxt_rxc_sync;
         rxd_sync_ff <= nxt_rxd_sync;
         txc_sync_ff <= nxt_txc_sync;
         txd_sync_ff <= nxt_txd_sync;
         rxc_ff      <= nxt_rxc;
         rxd_ff      <= nxt_rxd;
         txc_ff      <= nxt_txc;
         txd_ff      <= nxt_txd;
         rxc_prev_ff <= nxt_rxc_prev;
      end
   end

   // ------------------------------------------------------------
   // Test control register and soft reset
   // ------------------------------------------------------------
   logic [7:0] ctl_ff, nxt_ctl;
   logic [1:0] zero_wr_ff, nxt_zero_wr;
   logic       ctl_wr, low_wr, high_wr, soft_rst;
   assign ctl_wr  = reg_req.wr && (reg_req.addr == OFS_TEST_CONTROL);
   assign low_wr  = reg_req.wr && (reg_req.addr == OFS_TX_LENGTH_LOW);
   assign high_wr = reg_req.wr && (reg_req.addr == OFS_TX_LENGTH_HIGH);
   assign soft_rst = ctl_ff[BIT_SOFT_RESET];
   always_comb begin
      nxt_ctl     = ctl_ff;
      nxt_zero_wr = zero_wr_ff;
      if (ctl_wr) begin
         // Reserved bits stored as written; software keeps them zero
         nxt_ctl[6:0] = soft_rst ? RST_BYTE[6:0] : reg_req.wdata[6:0];
         if (reg_req.wdata[BIT_SOFT_RESET]) begin
            nxt_ctl[BIT_SOFT_RESET] = 1'b1;
            nxt_zero_wr = 2'h0;
         end else if (soft_rst) begin
            nxt_zero_wr = zero_wr_ff + 2'h1;
            if (zero_wr_ff + 2'h1 == ZERO_WRITES_CLR) begin
               nxt_ctl[BIT_SOFT_RESET] = 1'b0;
               nxt_zero_wr = 2'h0;
            end
         end
      end
      // Other control bits held cleared while soft reset stands
      if (soft_rst) begin
         nxt_ctl[6:0] = RST_BYTE[6:0];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff     <= RST_BYTE;
         zero_wr_ff <= 2'h0;
      end else begin
         ctl_ff     <= nxt_ctl;
         zero_wr_ff <= nxt_zero_wr;
      end
   end
   // ------------------------------------------------------------
   // Transmit length counter
   // ------------------------------------------------------------
   logic [7:0]  high_hold_ff, nxt_high_hold;
   logic [15:0] length_ff, nxt_length, count_ff, nxt_count;
   logic        tx_wr_req, tx_wr_done_ff, nxt_tx_wr_done;
   fifo_word_t  tx_word_sel;
   always_comb begin
      nxt_high_hold = high_hold_ff;
      nxt_length    = length_ff;
      nxt_count     = count_ff;
      nxt_tx_wr_done = tx_wr_req;
      if (high_wr) begin
         nxt_high_hold = reg_req.wdata;
      end
      if (low_wr) begin
         nxt_length = {high_hold_ff, reg_req.wdata};
         nxt_count  = {high_hold_ff, reg_req.wdata};
      end else if (tx_wr_done_ff && count_ff != RST_COUNT) begin
         // Decrement after the write has landed
         if (count_ff == COUNT_ONE) begin
            nxt_count = repeat_count_ctl ? length_ff : RST_COUNT;
         end else begin
            nxt_count = count_ff - COUNT_ONE;
         end
      end
      if (soft_rst) begin
         nxt_high_hold = RST_BYTE;
         nxt_length    = RST_COUNT;
         nxt_count     = RST_COUNT;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         high_hold_ff  <= RST_BYTE;
         length_ff     <= RST_COUNT;
         count_ff      <= RST_COUNT;
         tx_wr_done_ff <= 1'b0;
      end else begin
         high_hold_ff  <= nxt_high_hold;
         length_ff     <= nxt_length;
         count_ff      <= nxt_count;
         tx_wr_done_ff <= nxt_tx_wr_done;
      end
   end

   // ------------------------------------------------------------
   // FIFO routing: swap probe and receive loopback
   // ------------------------------------------------------------
   logic       swap, nxt_tx_wr, nxt_rx_wr, nxt_tx_rd, nxt_rx_rd;
   fifo_word_t nxt_tx_word, nxt_rx_word, nxt_cpu_rd;
   assign swap = ctl_ff[BIT_FIFO_SWAP];
   // Loopback byte wins the transmit write port; with swap off the processor write in that cycle is lost
   assign tx_wr_req = !soft_rst && ((cpu_tx_wr && !swap) ||
                      (rx_byte_valid && ctl_ff[BIT_RX_TO_TX]));
   always_comb begin
      tx_word_sel = cpu_tx_word;
      if (rx_byte_valid && ctl_ff[BIT_RX_TO_TX]) begin
         tx_word_sel = rx_byte;
      end
      nxt_tx_word = tx_word_sel;
      if (count_ff == COUNT_ONE) begin
         nxt_tx_word.end_tag = 1'b1;
      end
      nxt_tx_wr = tx_wr_req;
      // Receiver drops flags and CRC before rx_byte_valid
      nxt_rx_wr   = !soft_rst && (rx_byte_valid || (cpu_tx_wr && swap));
      nxt_rx_word = (cpu_tx_wr && swap) ? cpu_tx_word : rx_byte;
      nxt_tx_rd   = !soft_rst && cpu_rx_rd && swap;
      nxt_rx_rd   = !soft_rst && cpu_rx_rd && !swap;
      nxt_cpu_rd  = swap ? tx_fifo_out : rx_fifo_out;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_fifo_wr   <= 1'b0;
         tx_fifo_word <= '0;
         rx_fifo_wr   <= 1'b0;
         rx_fifo_word <= '0;
         tx_fifo_rd   <= 1'b0;
         rx_fifo_rd   <= 1'b0;
         cpu_rd_word  <= '0;
      end else begin
         tx_fifo_wr   <= nxt_tx_wr;
         tx_fifo_word <= nxt_tx_word;
         rx_fifo_wr   <= nxt_rx_wr;
         rx_fifo_word <= nxt_rx_word;
         tx_fifo_rd   <= nxt_tx_rd;
         rx_fifo_rd   <= nxt_rx_rd;
         cpu_rd_word  <= nxt_cpu_rd;
      end
   end

   // ------------------------------------------------------------
   // CRC and address probes
   // ------------------------------------------------------------
   probe_state_t state_ff, nxt_state;
   logic [4:0]  bits_ff, nxt_bits;
   logic [15:0] shift_ff, nxt_shift;
   logic        probe_on, rx_rise, crc_ok, addr_ok;
   assign probe_on = ctl_ff[BIT_CRC_PROBE] || ctl_ff[BIT_ADDR_PROBE];
   assign rx_rise  = rxc_ff && !rxc_prev_ff;
   // Mask flips single CRC bits so a failing checker can be exercised
   assign crc_ok   = ((shift_ff ^ crc_corrupt_mask) == CRC_REMAINDER);
   assign addr_ok  = (shift_ff == addr_match_value);
   always_comb begin
      nxt_state = state_ff;
      nxt_bits  = bits_ff;
      nxt_shift = shift_ff;
      case (state_ff)
         PROBE_IDLE: begin
            if (probe_on) begin
               nxt_state = PROBE_SHIFT;
               nxt_bits  = PROBE_RST;
            end
         end
         PROBE_SHIFT: begin
            if (rx_rise) begin
               nxt_shift = {shift_ff[14:0], rxd_ff};
               nxt_bits  = bits_ff + 5'h1;
               if (bits_ff + 5'h1 == PROBE_BITS) begin
                  nxt_state = PROBE_HALT;
               end
            end
         end
         PROBE_HALT: begin
            if (!probe_on) begin
               nxt_state = PROBE_IDLE;
            end
         end
         default: nxt_state = PROBE_IDLE;
      endcase
      if (!probe_on) begin
         nxt_state = PROBE_IDLE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= PROBE_IDLE;
         bits_ff  <= PROBE_RST;
         shift_ff <= RST_COUNT;
      end else begin
         state_ff <= nxt_state;
         bits_ff  <= nxt_bits;
         shift_ff <= nxt_shift;
      end
   end

   // ------------------------------------------------------------
   // Serial outputs, status and read data
   // ------------------------------------------------------------
   logic [7:0] status, nxt_rdata;
   logic       nxt_rx_data, nxt_run;
   always_comb begin
      status = RST_BYTE;
      status[BIT_RX_CLK_VIEW] = rxc_ff && receiver_enable_ctl;
      status[BIT_TX_CLK_VIEW] = txc_ff && transmitter_enable_ctl;
      status[BIT_CRC_MATCH]   = ctl_ff[BIT_CRC_PROBE] && crc_ok;
      status[BIT_ADDR_MATCH]  = ctl_ff[BIT_ADDR_PROBE] && addr_ok;
      // Software must also enable both directions for this loop
      nxt_rx_data = ctl_ff[BIT_TX_TO_RX] ? txd_ff : rxd_ff;
      nxt_run     = receiver_enable_ctl && (state_ff != PROBE_HALT);
      case (reg_req.addr)
         OFS_TX_LENGTH_LOW:  nxt_rdata = length_ff[7:0];
         OFS_TX_LENGTH_HIGH: nxt_rdata = high_hold_ff;
         OFS_TEST_CONTROL:   nxt_rdata = ctl_ff;
         OFS_TEST_STATUS:    nxt_rdata = status;
         default:            nxt_rdata = RST_BYTE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata           <= RST_BYTE;
         rx_data_to_receiver <= 1'b0;
         rx_clock_run        <= 1'b0;
         block_reset_b       <= 1'b0;
      end else begin
         reg_rdata           <= nxt_rdata;
         rx_data_to_receiver <= nxt_rx_data;
         rx_clock_run        <= nxt_run;
         block_reset_b       <= !soft_rst;
      end
   end
endmodule
`default_nettype wire

/* File: core/hdlc_test_pkg.sv */
// Package: offsets, fields, reset values and carriers for the HDLC test block
package hdlc_test_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_TX_LENGTH_LOW  = 5'h1A;
   localparam logic [4:0] OFS_TEST_CONTROL   = 5'h1B;
   localparam logic [4:0] OFS_TEST_STATUS    = 5'h1C;
   localparam logic [4:0] OFS_TX_LENGTH_HIGH = 5'h1F;
   // ------------------------------------------------------------
   // Test control fields
   // ------------------------------------------------------------
   localparam int BIT_SOFT_RESET = 7;
   localparam int BIT_RX_TO_TX   = 6;
   localparam int BIT_CRC_PROBE  = 3;
   localparam int BIT_FIFO_SWAP  = 2;
   localparam int BIT_ADDR_PROBE = 1;
   localparam int BIT_TX_TO_RX   = 0;
   // ------------------------------------------------------------
   // Status fields
   // ------------------------------------------------------------
   localparam int BIT_RX_CLK_VIEW = 3;
   localparam int BIT_TX_CLK_VIEW = 2;
   localparam int BIT_CRC_MATCH   = 1;
   localparam int BIT_ADDR_MATCH  = 0;
   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [15:0] RST_COUNT       = 16'h0000;
   localparam logic [15:0] COUNT_ONE       = 16'h0001;
   localparam logic [15:0] CRC_REMAINDER   = 16'hF0B8;
   localparam logic [4:0]  PROBE_BITS      = 5'h10;
   localparam logic [4:0]  PROBE_RST       = 5'h00;
   localparam logic [1:0]  ZERO_WRITES_CLR = 2'h2;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       end_tag;
      logic       abort_tag;
      logic [7:0] data;
   } fifo_word_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef enum logic [1:0] {PROBE_IDLE, PROBE_SHIFT, PROBE_HALT} probe_state_t;
endpackage

/* File: bench/hdlc_test_chk.sv */
// Port checker for the HDLC test block
`timescale 1ns/1ps
`default_nettype none
module hdlc_test_chk (
   // Clock and reset
   input wire logic                     clk_sys,
   input wire logic                     rst_b,
   // Requests
   input wire hdlc_test_pkg::reg_req_t  reg_req,
   input wire logic                     cpu_tx_wr,
   input wire hdlc_test_pkg::fifo_word_t cpu_tx_word,
   input wire logic                     cpu_rx_rd,
   input wire logic                     rx_byte_valid,
   input wire hdlc_test_pkg::fifo_word_t rx_byte,
   input wire logic                     receiver_enable_ctl,
   // Responses
   input wire logic                     tx_fifo_wr,
   input wire hdlc_test_pkg::fifo_word_t tx_fifo_word,
   input wire logic                     rx_fifo_wr,
   input wire hdlc_test_pkg::fifo_word_t rx_fifo_word,
   input wire logic                     tx_fifo_rd,
   input wire logic                     rx_fifo_rd,
   input wire logic                     rx_clock_run,
   input wire logic                     block_reset_b
);
   import hdlc_test_pkg::*;
   // ------------------------------------------------------------
   // Shadow of control bits 6:0
   // ------------------------------------------------------------
   logic [6:0] ctl_ff;
   logic [6:0] nxt_ctl;
   logic       ctl_wr;
   logic       zero_wr;
   logic       cpu_go;
   logic       soft_pend_ff;
   logic       nxt_soft_pend;
   assign ctl_wr  = reg_req.wr && reg_req.addr == OFS_TEST_CONTROL;
   assign zero_wr = ctl_wr && !reg_req.wdata[7];
   // With swap off, a looped byte wins over a processor write in the same cycle
   // Block reset trails the soft reset bit by one cycle
   assign cpu_go  = cpu_tx_wr && !(rx_byte_valid && ctl_ff[6]) && block_reset_b && !soft_pend_ff;
   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_soft_pend = ctl_wr && reg_req.wdata[7];
      if (!block_reset_b || (ctl_wr && reg_req.wdata[7]))
         nxt_ctl = 7'h00;
      else if (ctl_wr)
         nxt_ctl = reg_req.wdata[6:0];
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff       <= 7'h00;
         soft_pend_ff <= 1'b0;
      end else begin
         ctl_ff       <= nxt_ctl;
         soft_pend_ff <= nxt_soft_pend;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   a_soft_set_drops: assert property (ctl_wr && reg_req.wdata[7] |-> ##[1:2] !block_reset_b)
      else $error("soft reset set but block reset stayed high");
   a_soft_clear_cause: assert property ($rose(block_reset_b) && $past(rst_b, 2) |->
      $past(zero_wr) || $past(zero_wr, 2) || $past(zero_wr, 3))
      else $error("block reset released without a zero write");
   a_reset_no_strobe: assert property (!block_reset_b && $past(block_reset_b) == 1'b0 |->
      !tx_fifo_wr && !rx_fifo_wr)
      else $error("FIFO strobe during soft reset");
   a_loop_copy_both: assert property (rx_byte_valid && ctl_ff[6] && block_reset_b |=>
      tx_fifo_wr && rx_fifo_wr && rx_fifo_word == $past(rx_byte)
      && tx_fifo_word.data == $past(rx_byte.data))
      else $error("looped byte not written to both FIFOs");
   a_swap_write_path: assert property (cpu_go && ctl_ff[2] |=>
      rx_fifo_wr && !tx_fifo_wr && rx_fifo_word == $past(cpu_tx_word))
      else $error("swapped write not redirected");
   a_swap_read_path: assert property (cpu_rx_rd && ctl_ff[2] && block_reset_b |=>
      tx_fifo_rd && !rx_fifo_rd)
      else $error("swapped read not redirected");
   a_plain_write_path: assert property (cpu_go && !ctl_ff[2] |=>
      tx_fifo_wr && !rx_fifo_wr && tx_fifo_word.data == $past(cpu_tx_word.data))
      else $error("processor write lost");
   a_rx_clock_gate: assert property (!receiver_enable_ctl |=> !rx_clock_run)
      else $error("receive clock runs while disabled");
   a_probe_halt_cause: assert property ($fell(rx_clock_run) && $past(receiver_enable_ctl)
      && block_reset_b |-> ctl_ff[3] || ctl_ff[1])
      else $error("receive clock stopped with no probe set");
endmodule
bind hdlc_txcount_test_loopback hdlc_test_chk u_chk (.clk_sys, .rst_b, .reg_req, .cpu_tx_wr,
   .cpu_tx_word, .cpu_rx_rd, .rx_byte_valid, .rx_byte, .receiver_enable_ctl, .tx_fifo_wr,
   .tx_fifo_word, .rx_fifo_wr, .rx_fifo_word, .tx_fifo_rd, .rx_fifo_rd, .rx_clock_run,
   .block_reset_b);
`default_nettype wire

/* File: bench/hdlc_far_end.sv */
// Far-end model: framer serial source and FIFO output words
`timescale 1ns/1ps
`default_nettype none
module hdlc_far_end (
   // Clock
   input  wire logic                      clk_sys,
   // Serial timeslot path
   output var logic                       rx_serial_clock,
   output var logic                       rx_serial_data,
   // FIFO outputs
   output var hdlc_test_pkg::fifo_word_t  tx_fifo_out,
   output var hdlc_test_pkg::fifo_word_t  rx_fifo_out
);
   import hdlc_test_pkg::*;
   // Slow enough for the input synchroniser
   localparam int HALF_BIT = 8;
   initial begin
      rx_serial_clock = 1'b0;
      rx_serial_data  = 1'b0;
   end
   assign tx_fifo_out = '{end_tag: 1'b1, abort_tag: 1'b0, data: 8'hC3};
   assign rx_fifo_out = '{end_tag: 1'b0, abort_tag: 1'b1, data: 8'h3C};
   // Clock idles low between frames; data flips once the frame ends
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         rx_serial_data = w[i];
         repeat (HALF_BIT) @(posedge clk_sys);
         #1 rx_serial_clock = 1'b1;
         repeat (HALF_BIT) @(posedge clk_sys);
         #1 rx_serial_clock = 1'b0;
      end
      rx_serial_data = ~rx_serial_data;
   endtask
   // Parks the clock at a level between frames
   task automatic hold_clock(input logic v);
      rx_serial_clock = v;
   endtask
endmodule
`default_nettype wire

/* File: bench/hdlc_txcount_test_loopback_test.sv */
// Self-checking bench for the HDLC test block
`timescale 1ns/1ps
`default_nettype none
module hdlc_txcount_test_loopback_test;
   import hdlc_test_pkg::*;
   logic        clk_sys, rst_b, cpu_tx_wr, cpu_rx_rd, rx_byte_valid, tx_fifo_wr, rx_fifo_wr;
   logic        tx_fifo_rd, rx_fifo_rd, repeat_count_ctl, receiver_enable_ctl;
   logic        transmitter_enable_ctl, rx_serial_clock, rx_serial_data, tx_bit_clock;
   logic        tx_serial_data, rx_data_to_receiver, rx_clock_run, block_reset_b;
   logic [7:0]  reg_rdata, d;
   logic [15:0] addr_match_value, crc_corrupt_mask;
   reg_req_t    reg_req;
   fifo_word_t  cpu_tx_word, tx_fifo_out, rx_fifo_out, cpu_rd_word, rx_byte;
   fifo_word_t  tx_fifo_word, rx_fifo_word;
   int          bad_count, tests_run;
   hdlc_txcount_test_loopback u_dut (.clk_sys, .rst_b, .reg_req, .reg_rdata, .cpu_tx_wr,
      .cpu_tx_word, .cpu_rx_rd, .tx_fifo_out, .rx_fifo_out, .cpu_rd_word, .rx_byte_valid,
      .rx_byte, .tx_fifo_wr, .tx_fifo_word, .rx_fifo_wr, .rx_fifo_word, .tx_fifo_rd,
      .rx_fifo_rd, .repeat_count_ctl, .receiver_enable_ctl, .transmitter_enable_ctl,
      .rx_serial_clock, .rx_serial_data, .tx_bit_clock, .tx_serial_data, .addr_match_value,
      .crc_corrupt_mask, .rx_data_to_receiver, .rx_clock_run, .block_reset_b);
   hdlc_far_end u_far (.clk_sys, .rx_serial_clock, .rx_serial_data, .tx_fifo_out,
      .rx_fifo_out);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic cyc(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [4:0] a, input logic [7:0] v);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      cyc();
      reg_req.wr = 1'b0;
      cyc();
   endtask
   task automatic rreg(input logic [4:0] a);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      cyc();
      d = reg_rdata;
   endtask
   // Spaced writes so each decrement lands before the next write
   task automatic tx_tags(input int n, input logic [7:0] pat);
      for (int i = 0; i < n; i++) begin
         cpu_tx_wr = 1'b1;
         cyc();
         cpu_tx_wr = 1'b0;
         check({tx_fifo_wr, tx_fifo_word.end_tag}, {1'b1, pat[i]});
         cyc(3);
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_count;
      wreg(OFS_TX_LENGTH_LOW, 8'h03);
      tx_tags(4, 8'h04);
      repeat_count_ctl = 1'b1;
      wreg(OFS_TX_LENGTH_LOW, 8'h02);
      tx_tags(4, 8'h0A);
      repeat_count_ctl = 1'b0;
      wreg(OFS_TX_LENGTH_HIGH, 8'h01);
      tx_tags(2, 8'h02);
      rreg(OFS_TX_LENGTH_HIGH);
      check(d, 8'h01);
      wreg(OFS_TX_LENGTH_LOW, 8'h01);
      tx_tags(1, 8'h00);
      wreg(OFS_TX_LENGTH_HIGH, 8'h00);
      $display("test count done");
   endtask
   task automatic t_soft;
      wreg(OFS_TX_LENGTH_LOW, 8'h01);
      wreg(OFS_TEST_CONTROL, 8'h80);
      cyc(2);
      check(block_reset_b, 1'b0);
      rreg(OFS_TEST_CONTROL);
      check(d, 8'h80);
      wreg(OFS_TEST_CONTROL, 8'h00);
      cyc(2);
      check(block_reset_b, 1'b0);
      wreg(OFS_TEST_CONTROL, 8'h80);
      wreg(OFS_TEST_CONTROL, 8'h00);
      cyc(3);
      check(block_reset_b, 1'b0);
      wreg(OFS_TEST_CONTROL, 8'h00);
      cyc(3);
      check(block_reset_b, 1'b1);
      tx_tags(1, 8'h00);
      $display("test soft reset done");
   endtask
   task automatic t_loops;
      wreg(OFS_TEST_CONTROL, 8'h40);
      rx_byte = '{end_tag: 1'b1, abort_tag: 1'b0, data: 8'h5A};
      rx_byte_valid = 1'b1;
      cyc();
      rx_byte_valid = 1'b0;
      check({tx_fifo_wr, rx_fifo_wr}, 2'b11);
      check(tx_fifo_word, rx_byte);
      wreg(OFS_TEST_CONTROL, 8'h04);
      cpu_tx_word = '{end_tag: 1'b1, abort_tag: 1'b1, data: 8'hA5};
      cpu_tx_wr = 1'b1;
      cyc();
      cpu_tx_wr = 1'b0;
      check({tx_fifo_wr, rx_fifo_wr}, 2'b01);
      check(rx_fifo_word, cpu_tx_word);
      cpu_rx_rd = 1'b1;
      cyc();
      cpu_rx_rd = 1'b0;
      check({tx_fifo_rd, rx_fifo_rd}, 2'b10);
      cyc();
      check(cpu_rd_word, tx_fifo_out);
      wreg(OFS_TEST_CONTROL, 8'h01);
      tx_serial_data = ~rx_serial_data;
      cyc(8);
      check(rx_data_to_receiver, tx_serial_data);
      wreg(OFS_TEST_CONTROL, 8'h00);
      cyc(8);
      check(rx_data_to_receiver, rx_serial_data);
      check(cpu_rd_word, rx_fifo_out);
      $display("test loops done");
   endtask
   task automatic t_probe;
      u_far.hold_clock(1'b1);
      for (int e = 0; e < 2; e++) begin
         transmitter_enable_ctl = e[0];
         receiver_enable_ctl = e[0];
         cyc(8);
         rreg(OFS_TEST_STATUS);
         check(d[3:2], {e[0], e[0]});
      end
      u_far.hold_clock(1'b0);
      addr_match_value = CRC_REMAINDER;
      wreg(OFS_TEST_CONTROL, 8'h0A);
      cyc(8);
      check(rx_clock_run, 1'b1);
      u_far.send_word(CRC_REMAINDER);
      cyc(8);
      check(rx_clock_run, 1'b0);
      rreg(OFS_TEST_STATUS);
      check(d[1:0], 2'b11);
      crc_corrupt_mask = 16'h0001;
      cyc(8);
      rreg(OFS_TEST_STATUS);
      check(d[1:0], 2'b01);
      wreg(OFS_TEST_CONTROL, 8'h00);
      cyc(8);
      check(rx_clock_run, 1'b1);
      $display("test probes done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #40000;
      bad_count++;
      finish_test();
   end
   initial begin
      {rst_b, cpu_tx_wr, cpu_rx_rd, rx_byte_valid, repeat_count_ctl} = '0;
      {tx_bit_clock, tx_serial_data, addr_match_value, crc_corrupt_mask} = '0;
      {receiver_enable_ctl, transmitter_enable_ctl} = 2'b11;
      reg_req = '0;
      cpu_tx_word = '{end_tag: 1'b0, abort_tag: 1'b0, data: 8'h11};
      rx_byte = '0;
      bad_count = 0;
      tests_run = 0;
      cyc(20);
      rst_b = 1'b1;
      cyc();
      tx_bit_clock = 1'b1;
      t_count();
      t_soft();
      t_loops();
      t_probe();
      finish_test();
   end
endmodule
`default_nettype wire
